/* verilog/see_pkg.sv */
// Purpose: Shared constants and types of the serial memory command logic
// Assumes: ref_clk at 40 MHz
// Notes:   Opcode and sub-command encodings follow the serial word format
package see_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Array shape
   localparam int unsigned ADDR_W = 6;          // Word address width
   localparam int unsigned DATA_W = 16;         // Word width
   localparam int unsigned WORDS  = 64;         // Number of words
   // Opcodes after the start bit
   localparam logic [1:0] OP_EXT   = 2'h0;      // Sub-command in address
   localparam logic [1:0] OP_WRITE = 2'h1;      // Word write
   localparam logic [1:0] OP_READ  = 2'h2;      // Read with auto-increment
   localparam logic [1:0] OP_ERASE = 2'h3;      // Word erase
   // Sub-commands in the top two address bits
   localparam logic [1:0] EXT_DISABLE = 2'h0;   // program_disable_cmd
   localparam logic [1:0] EXT_FILL    = 2'h1;   // fill_all_cmd
   localparam logic [1:0] EXT_CLEAR   = 2'h2;   // clear_all_cmd
   localparam logic [1:0] EXT_ENABLE  = 2'h3;   // Program enable
   // Bit counter end values
   localparam logic [3:0] OPC_LAST  = 4'h1;     // Second opcode bit
   localparam logic [3:0] ADDR_LAST = 4'h5;     // Sixth address bit
   // Values after reset and erase
   localparam logic [15:0] ERASED_WORD = 16'hFFFF; // All ones
   localparam logic        WEN_RESET   = 1'b0;     // Write-disabled
   // Self-timed programming time, longest figure rounded down
   localparam int unsigned CLK_HZ  = 40000000;  // ref_clk rate
   localparam int unsigned TWP_MS  = 10;        // Write cycle time
   localparam int unsigned TWP_CYC = (TWP_MS * (CLK_HZ / 1000)); // Cycles
   ////////////////////////////////////////////////////////////////////////
   // Programming operation kinds
   typedef enum logic [1:0] {
      PG_WRITE = 2'h0,
      PG_FILL  = 2'h1,
      PG_ERASE = 2'h2,
      PG_CLEAR = 2'h3
   } see_pop_t;
endpackage

/* verilog/see_mem.sv */
// Purpose: Word array with one write port and a registered read port
// Assumes: Single clock, write and read may hit the same word
// Notes:   Array content has no reset, like the cells it models
`timescale 1ns/1ps
module see_mem
   import see_pkg::*;
#(
   parameter int unsigned AW = ADDR_W,
   parameter int unsigned DW = DATA_W
)(
   input  wire logic          ref_clk, // Clock
   input  wire logic          arst_n,  // Async reset, active low
   input  wire logic          wr_en,   // Write strobe
   input  wire logic [AW-1:0] wr_addr, // Write address
   input  wire logic [DW-1:0] wr_data, // Write data
   input  wire logic [AW-1:0] rd_addr, // Read address
   output logic      [DW-1:0] rd_q     // Registered read data
);
   logic [DW-1:0] mem_q [2**AW];       // Storage

   ////////////////////////////////////////////////////////////////////////
   // Array write
   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
         mem_q[wr_addr] <= wr_data;
   end

   // Registered read
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         rd_q <= '0;
      else
         rd_q <= mem_q[rd_addr];
   end
endmodule

/* verilog/see_prog.sv */
// Purpose: Self-timed programming sequencer for word and whole-array ops
// Assumes: start is a one-cycle pulse, never while busy
// Notes:   Each cycle erases first, writes for word write and fill only, then waits out the time
`timescale 1ns/1ps
module see_prog
   import see_pkg::*;
#(
   parameter int unsigned TWP_CYCLES = TWP_CYC
)(
   input  wire logic              ref_clk, // Clock
   input  wire logic              arst_n,  // Async reset, active low
   input  wire logic              start,   // Begin programming
   input  wire see_pop_t          pop,     // Operation kind
   input  wire logic [ADDR_W-1:0] addr,    // Target word
   input  wire logic [DATA_W-1:0] data,    // Word to write
   output logic                   busy,    // Programming in progress
   output logic                   wr_en,   // Array write strobe
   output logic      [ADDR_W-1:0] wr_addr, // Array write address
   output logic      [DATA_W-1:0] wr_data  // Array write data
);
   localparam int unsigned TW = $clog2(TWP_CYCLES + 1); // Timer width

   typedef enum logic [1:0] {
      PS_IDLE  = 2'h0,
      PS_ERASE = 2'h1,
      PS_WRITE = 2'h3,
      PS_WAIT  = 2'h2
   } see_ps_t;

   see_ps_t           st_q;            // Sequencer state
   see_pop_t          pop_q;           // Latched operation
   logic [ADDR_W-1:0] ptr_q;           // Word pointer
   logic [DATA_W-1:0] data_q;          // Latched data
   logic [TW-1:0]     tmr_q;           // Cycle time counter

   // Whole-array pass must fit inside the programming time
   if (TWP_CYCLES < 2 * WORDS + 2)
   begin : g_twp_chk
      $error("TWP_CYCLES too small for a whole-array pass");
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode
   wire all_w  = (pop_q == PG_FILL) || (pop_q == PG_CLEAR);
   wire last_w = !all_w || (ptr_q == ADDR_W'(WORDS - 1));
   wire wr_w   = (pop_q == PG_WRITE) || (pop_q == PG_FILL);

   assign busy    = (st_q != PS_IDLE);
   assign wr_en   = (st_q == PS_ERASE) || (st_q == PS_WRITE);
   assign wr_addr = ptr_q;
   // Erase phase writes ones before any data phase
   assign wr_data = (st_q == PS_ERASE) ? ERASED_WORD : data_q;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q   <= PS_IDLE;
         pop_q  <= PG_WRITE;
         ptr_q  <= '0;
         data_q <= '0;
         tmr_q  <= '0;
      end
      else
      begin
         if (st_q != PS_IDLE)
            tmr_q <= tmr_q - TW'(1);
         case (st_q)
            PS_IDLE:
               if (start)
               begin
                  st_q   <= PS_ERASE;
                  pop_q  <= pop;
                  data_q <= data;
                  tmr_q  <= TW'(TWP_CYCLES - 1);
                  // Whole-array ops walk from word zero
                  ptr_q  <= (pop == PG_FILL || pop == PG_CLEAR) ? '0 : addr;
               end
            PS_ERASE:
               if (last_w)
               begin
                  st_q  <= wr_w ? PS_WRITE : PS_WAIT;
                  ptr_q <= all_w ? '0 : ptr_q;
               end
               else
                  ptr_q <= ptr_q + ADDR_W'(1);
            PS_WRITE:
               if (last_w)
                  st_q <= PS_WAIT;
               else
                  ptr_q <= ptr_q + ADDR_W'(1);
            PS_WAIT:
               if (tmr_q == '0)
                  st_q <= PS_IDLE;
            default:
               st_q <= PS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_erase_first: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $rose(st_q == PS_WRITE) |-> $past(st_q) == PS_ERASE)
      else $error("write phase without erase");
endmodule

/* verilog/see_core.sv */
// Purpose: Serial instruction decode, read stream and program control
// Assumes: Pins are asynchronous to ref_clk and far slower than it
// Notes:   Command state never moves without a serial clock edge or chip select change
`timescale 1ns/1ps
module see_core
   import see_pkg::*;
#(
   parameter int unsigned TWP_CYCLES = TWP_CYC
)(
   input  wire logic ref_clk,       // 40 MHz clock
   input  wire logic arst_n,        // Async reset, active low
   input  wire logic serial_clock,  // Serial clock pin
   input  wire logic chip_sel,      // Chip select pin, active high
   input  wire logic serial_in,     // Serial data input pin
   output logic      serial_out,    // Serial data output
   output logic      serial_out_oe  // Output enable, high drives
);
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_OPC    = 3'h1,
      ST_ADDR   = 3'h3,
      ST_READ   = 3'h2,
      ST_DATA   = 3'h6,
      ST_ARMED  = 3'h7,
      ST_IGNORE = 3'h5
   } see_st_t;

   logic [2:0]        sync1_q;      // First sync stage
   logic [2:0]        sync2_q;      // Second sync stage
   logic              sk_p_q;       // Previous serial clock
   logic              cs_p_q;       // Previous chip select
   see_st_t           st_q;         // Command state
   logic [3:0]        cnt_q;        // Bit counter
   logic [1:0]        op_q;         // Opcode shifter
   logic [ADDR_W-1:0] addr_q;       // Address shifter
   logic [DATA_W-1:0] data_q;       // Data shifter
   logic [DATA_W-1:0] sh_q;         // Read shift register
   logic [ADDR_W-1:0] rd_addr_q;    // Read pointer
   logic              wen_q;        // Programming enabled
   logic              status_q;     // Ready/busy flag armed
   logic              do_q;         // Output data flop
   logic [DATA_W-1:0] rd_data;      // Array read data
   logic              busy;         // Programming running
   logic              wr_en;        // Array write strobe
   logic [ADDR_W-1:0] wr_addr;      // Array write address
   logic [DATA_W-1:0] wr_data;      // Array write data

   ////////////////////////////////////////////////////////////////////////
   // Functions
   // State after the last address bit
   function automatic see_st_t after_addr(input logic [1:0] op,
                                          input logic [1:0] ext,
                                          input logic       en);
      after_addr = ST_IGNORE;
      case (op)
         OP_READ:  after_addr = ST_READ;
         OP_WRITE: after_addr = en ? ST_DATA : ST_IGNORE;
         OP_ERASE: after_addr = en ? ST_ARMED : ST_IGNORE;
         default:
            if (ext == EXT_FILL)
               after_addr = en ? ST_DATA : ST_IGNORE;
            else if (ext == EXT_CLEAR)
               after_addr = en ? ST_ARMED : ST_IGNORE;
            else
               after_addr = ST_IGNORE;
      endcase
   endfunction

   // Programming kind from opcode and sub-command
   function automatic see_pop_t prog_kind(input logic [1:0] op,
                                          input logic [1:0] ext);
      case (op)
         OP_WRITE: prog_kind = PG_WRITE;
         OP_ERASE: prog_kind = PG_ERASE;
         default:  prog_kind = (ext == EXT_FILL) ? PG_FILL : PG_CLEAR;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sk_p_q  <= 1'b0;
         cs_p_q  <= 1'b0;
      end
      else
      begin
         sync1_q <= {serial_in, chip_sel, serial_clock};
         sync2_q <= sync1_q;
         sk_p_q  <= sync2_q[0];
         cs_p_q  <= sync2_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event decode
   wire din      = sync2_q[2];
   wire cs_hi    = sync2_q[1];
   wire sk_rise  = sync2_q[0] & ~sk_p_q;
   wire cs_fall  = cs_p_q & ~cs_hi;
   wire shift    = sk_rise & cs_hi;
   wire [ADDR_W-1:0] addr_nx = {addr_q[ADDR_W-2:0], din};
   wire [1:0] ext_nx = addr_nx[ADDR_W-1:ADDR_W-2];
   wire addr_done = shift && (st_q == ST_ADDR) && (cnt_q == ADDR_LAST);
   wire is_ext    = (op_q == OP_EXT);
   wire en_cmd    = addr_done && is_ext && (ext_nx == EXT_ENABLE);
   wire dis_cmd   = addr_done && is_ext && (ext_nx == EXT_DISABLE);
   wire rd_cmd    = addr_done && (op_q == OP_READ);
   wire rd_load   = shift && (st_q == ST_READ) && (cnt_q == 4'h0);
   // Deselect after a pending programming command starts it
   wire prog_start = cs_fall && ((st_q == ST_DATA) || (st_q == ST_ARMED));
   wire prog_cmd  = (op_q == OP_WRITE) || (op_q == OP_ERASE) ||
                    (is_ext && (ext_nx == EXT_FILL || ext_nx == EXT_CLEAR));

   ////////////////////////////////////////////////////////////////////////
   // Command state machine
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q   <= ST_IDLE;
         cnt_q  <= 4'h0;
         op_q   <= 2'h0;
         addr_q <= '0;
         data_q <= '0;
      end
      else if (!cs_hi)
         st_q <= ST_IDLE;
      else if (shift)
      begin
         cnt_q <= cnt_q + 4'h1;
         case (st_q)
            // Start bit; new commands are ignored while busy
            ST_IDLE:
            begin
               cnt_q <= 4'h0;
               if (din)
                  st_q <= busy ? ST_IGNORE : ST_OPC;
            end
            ST_OPC:
            begin
               op_q <= {op_q[0], din};
               if (cnt_q == OPC_LAST)
               begin
                  st_q  <= ST_ADDR;
                  cnt_q <= 4'h0;
               end
            end
            ST_ADDR:
            begin
               addr_q <= addr_nx;
               if (cnt_q == ADDR_LAST)
               begin
                  st_q  <= after_addr(op_q, ext_nx, wen_q);
                  cnt_q <= 4'h0;
               end
            end
            // Keep only the last sixteen bits
            ST_DATA:
               data_q <= {data_q[DATA_W-2:0], din};
            default:
               st_q <= st_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Program enable latch
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         wen_q <= WEN_RESET;
      else if (en_cmd)
         wen_q <= 1'b1;
      else if (dis_cmd)
         wen_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Ready/busy flag, set wins over clear
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         status_q <= 1'b0;
      else if (prog_start)
         status_q <= 1'b1;
      else if (shift && din)
         status_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read stream and output flop
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         do_q      <= 1'b0;
         sh_q      <= '0;
         rd_addr_q <= '0;
      end
      else if (rd_cmd)
      begin
         do_q      <= 1'b0;
         rd_addr_q <= addr_nx;
      end
      else if (rd_load)
      begin
         do_q      <= rd_data[DATA_W-1];
         sh_q      <= {rd_data[DATA_W-2:0], 1'b0};
         rd_addr_q <= rd_addr_q + ADDR_W'(1);
      end
      else if (shift && st_q == ST_READ)
      begin
         do_q <= sh_q[DATA_W-1];
         sh_q <= {sh_q[DATA_W-2:0], 1'b0};
      end
      else if (st_q != ST_READ)
         do_q <= ~busy;
   end

   // Drive only for read data or status
   assign serial_out_oe = cs_hi && ((st_q == ST_READ) ||
                          (st_q == ST_IDLE && status_q));
   assign serial_out    = do_q;

   ////////////////////////////////////////////////////////////////////////
   // Programming sequencer and array
   see_prog #(
      .TWP_CYCLES (TWP_CYCLES)
   ) u_prog (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .start   (prog_start),
      .pop     (prog_kind(op_q, addr_q[ADDR_W-1:ADDR_W-2])),
      .addr    (addr_q),
      .data    (data_q),
      .busy    (busy),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data)
   );

   see_mem #(
      .AW (ADDR_W),
      .DW (DATA_W)
   ) u_mem (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .rd_addr (rd_addr_q),
      .rd_q    (rd_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_oe_released: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !cs_hi |-> !serial_out_oe)
      else $error("output driven while deselected");

   a_dummy_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_cmd |=> (serial_out == 1'b0) && (st_q == ST_READ))
      else $error("read did not lead with zero");

   a_enable_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
      en_cmd |=> wen_q)
      else $error("enable command not taken");

   a_disable_clr: assert property (@(posedge ref_clk) disable iff (!arst_n)
      dis_cmd |=> !wen_q)
      else $error("disable command not taken");

   a_locked_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
      addr_done && prog_cmd && !wen_q |=> st_q == ST_IGNORE)
      else $error("programming accepted while disabled");

   a_prog_busy: assert property (@(posedge ref_clk) disable iff (!arst_n)
      prog_start |=> busy ##1 busy)
      else $error("programming did not start");

   a_flag_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
      shift && din |=> !status_q)
      else $error("ready/busy flag not cleared");

   a_status_show: assert property (@(posedge ref_clk) disable iff (!arst_n)
      serial_out_oe && st_q == ST_IDLE && $stable(st_q) |-> serial_out == !$past(busy))
      else $error("status level wrong");

   a_read_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $past(arst_n) && st_q != ST_READ && $past(st_q) != ST_READ |-> serial_out == !$past(busy))
      else $error("stored data shown outside read");

   a_addr_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_load |=> rd_addr_q == ADDR_W'($past(rd_addr_q) + ADDR_W'(1)))
      else $error("read pointer did not advance");

   a_edge_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $changed(do_q) && st_q == ST_READ && $past(st_q) == ST_READ |-> $past(shift))
      else $error("read data moved off a clock edge");

   a_state_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $changed(st_q) |-> $past(shift || !cs_hi))
      else $error("state moved without an edge");
endmodule

/* dv/see_host.sv */
// Purpose: Host model that drives the serial pins of the command logic
// Assumes: ref_clk at 40 MHz; pins change at its falling edge
// Notes:   Serial clock rests low between frames; phases last many cycles
`timescale 1ns/1ps
module see_host
   import see_pkg::*;
(
   input  wire logic ref_clk,      // 40 MHz clock
   output logic      serial_clock, // Serial clock pin
   output logic      chip_sel,     // Chip select pin
   output logic      serial_in,    // Serial data pin
   input  wire logic serial_out,   // Device data out
   input  wire logic serial_out_oe // Device output enable
);
   ////////////////////////////////////////////////////////////////////////
   // Pins idle at time zero
   initial
   begin
      serial_clock = 1'b0;
      chip_sel     = 1'b0;
      serial_in    = 1'b0;
   end

   // Wait on falling edges
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Select change, held long enough for the minimum deselect time
   task automatic sel(input logic v);
      chip_sel = v;
      idle(12);
   endtask

   // One serial clock period; a released output reads as z
   task automatic clk_bit(input logic b, output logic got);
      serial_in = b;
      idle(4);
      serial_clock = 1'b1;
      idle(5);
      serial_clock = 1'b0;
      idle(4);
      got = serial_out_oe ? serial_out : 1'bz;
   endtask

   // Shift n bits MSB first, then leave data low; any high bit shifted clears status
   task automatic send(input int n, input logic [31:0] v, output logic got);
      for (int i = n - 1; i >= 0; i--)
         clk_bit(v[i], got);
      serial_in = 1'b0;
   endtask
endmodule

/* dv/test_see_core.sv */
// Purpose: Self-checking bench of the serial memory command logic
// Assumes: Shortened programming time of 200 cycles
// Notes:   Host model drives the pins; bench judges each scenario
`timescale 1ns/1ps
module test_see_core
   import see_pkg::*;
;
   localparam int unsigned TWP = 200; // Shortened programming time
   logic ref_clk;       // Clock
   logic arst_n;        // Reset, active low
   logic serial_clock;  // Serial clock pin
   logic chip_sel;      // Chip select pin
   logic serial_in;     // Serial data pin
   logic serial_out;    // Data out
   logic serial_out_oe; // Output enable
   logic g;             // Last bit seen
   logic [15:0] w;      // Word seen
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   see_core #(
      .TWP_CYCLES (TWP)
   ) DUT (
      .ref_clk       (ref_clk),       // Clock
      .arst_n        (arst_n),        // Reset
      .serial_clock  (serial_clock),  // From host
      .chip_sel      (chip_sel),      // From host
      .serial_in     (serial_in),     // From host
      .serial_out    (serial_out),    // To host
      .serial_out_oe (serial_out_oe)  // To host
   );
   see_host host (
      .ref_clk       (ref_clk),       // Clock
      .serial_clock  (serial_clock),  // To device
      .chip_sel      (chip_sel),      // To device
      .serial_in     (serial_in),     // To device
      .serial_out    (serial_out),    // From device
      .serial_out_oe (serial_out_oe)  // From device
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang limit
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         summarize();
      end
   end

   // Verdict
   task automatic summarize;
      if (mismatches == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Compare seen against expected
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Select and shift start bit, opcode, address
   task automatic cmd(input logic [1:0] op, input logic [5:0] a);
      host.sel(1'b1);
      host.send(9, {23'h0, 1'b1, op, a}, g);
   endtask

   // Sub-command without data
   task automatic ext(input logic [1:0] sub);
      cmd(OP_EXT, {sub, 4'hA});
      host.sel(1'b0);
   endtask

   // Write with a twenty-bit data field; last sixteen count
   task automatic wr(input logic [5:0] a, input logic [19:0] d);
      cmd(OP_WRITE, a);
      host.send(20, {12'h0, d}, g);
      host.sel(1'b0);
   endtask

   // Busy then ready on reselect, released on deselect
   task automatic wait_ready;
      host.sel(1'b1);
      check({serial_out_oe, serial_out}, 16'h0002);
      host.idle(TWP);
      check({serial_out_oe, serial_out}, 16'h0003);
      host.sel(1'b0);
      check(serial_out_oe, 16'h0000);
   endtask

   // Two streamed words with a pause of the serial clock between
   task automatic rd_check(input logic [5:0] a, input logic [15:0] e0,
                           input logic [15:0] e1);
      cmd(OP_READ, a);
      check(g, 16'h0000);
      for (int i = 0; i < 16; i++)
      begin
         host.clk_bit(1'b0, g);
         w = {w[14:0], g};
      end
      check(w, e0);
      host.idle(40);
      for (int i = 0; i < 16; i++)
      begin
         host.clk_bit(1'b0, g);
         w = {w[14:0], g};
      end
      check(w, e1);
      host.sel(1'b0);
      check(serial_out_oe, 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      arst_n = 1'b0;
      repeat (8) @(negedge ref_clk);
      arst_n = 1'b1;
      host.idle(8);
      ext(EXT_ENABLE);
      cmd(OP_EXT, {EXT_FILL, 4'h5});
      host.send(16, 32'h0000A5C3, g);
      host.sel(1'b0);
      wait_ready();
      // Status shown again, then cleared by select and input high
      host.sel(1'b1);
      check({serial_out_oe, serial_out}, 16'h0003);
      host.send(1, 32'h1, g);
      host.sel(1'b0);
      host.sel(1'b1);
      check(serial_out_oe, 16'h0000);
      host.sel(1'b0);
      rd_check(6'h3F, 16'hA5C3, 16'hA5C3);
      ext(EXT_DISABLE);
      wr(6'h05, 20'hF1234);
      host.sel(1'b1);
      check(serial_out_oe, 16'h0000);
      host.sel(1'b0);
      rd_check(6'h05, 16'hA5C3, 16'hA5C3);
      ext(EXT_ENABLE);
      wr(6'h05, 20'hF1234);
      wait_ready();
      ext(EXT_DISABLE);
      rd_check(6'h04, 16'hA5C3, 16'h1234);
      ext(EXT_ENABLE);
      cmd(OP_ERASE, 6'h06);
      host.sel(1'b0);
      wait_ready();
      rd_check(6'h05, 16'h1234, 16'hFFFF);
      cmd(OP_EXT, {EXT_CLEAR, 4'h3});
      host.sel(1'b0);
      wait_ready();
      rd_check(6'h00, 16'hFFFF, 16'hFFFF);
      // Command started while busy is ignored
      wr(6'h07, 20'h0ABCD);
      cmd(OP_READ, 6'h07);
      check(serial_out_oe, 16'h0000);
      host.sel(1'b0);
      host.idle(TWP);
      rd_check(6'h07, 16'hABCD, 16'hFFFF);
      ext(EXT_DISABLE);
      summarize();
   end
endmodule
